// ---- rtl/tpc_defines.vh ----
// Constants for the two-channel PWM timer block
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH
// Prescale select codes
`define TPC_PS_EXT 3'h7
// Mode select pairs (link bit : unbuffered select bit)
`define TPC_MODE_UNBUF 2'h1
`define TPC_MODE_BUF 2'h2
// Edge/level select actions on compare
`define TPC_ELS_CLEAR 2'h2
`define TPC_ELS_SET 2'h3
`define TPC_ELS_TOGGLE 2'h1
// Reset values
`define TPC_PERIOD_RST 16'hFFFF
`define TPC_COUNT_RST 16'h0000
`define TPC_PS_RST 3'h0
// Prescaler width: divide up to 64
`define TPC_PRE_W 6
`endif

// ---- rtl/tpc_prescaler.v ----
// Counter clock-enable source: bus clock prescaler or external count clock
`timescale 1ns/1ps
`include "tpc_defines.vh"
module tpc_prescaler
(
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Control
  input wire clearPre,
  input wire run,
  input wire [2:0] prescaleSelect,
  input wire extCountClock,
  // Tick out
  output reg tick
);
  reg [`TPC_PRE_W-1:0] preCount; // Free divider
  reg extSync1; // External clock first stage
  reg extSync2; // Second stage
  reg extLast; // Edge detector history
  wire [`TPC_PRE_W-1:0] preMask; // Low bits that must be all ones
  // Mask picks the divide ratio 1..64
  assign preMask = (6'h1 << prescaleSelect) - 6'h1;

  // Divider and external-edge tick; halted while not running (stop/break/halt)
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      preCount <= 6'h00;
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extLast <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      extSync1 <= extCountClock;
      extSync2 <= extSync1;
      extLast <= extSync2;
      if (clearPre)
      begin
        preCount <= 6'h00;
        tick <= 1'b0;
      end
      else if (!run)
        tick <= 1'b0;
      else if (prescaleSelect == `TPC_PS_EXT)
        // Rising edge of the pin counts once
        tick <= extSync2 & ~extLast;
      else
      begin
        preCount <= preCount + 6'h01;
        tick <= ((preCount & preMask) == preMask);
      end
    end
  end
endmodule

// ---- rtl/tpc_pwm_pair.v ----
// Two-channel 16-bit PWM timer with linked buffered mode and flag logic
// Overview of operation
// - Unbuffered channel value applies immediately when written
// - Counter match with channel value raises compare
// - Overflow event when counter reaches period limit
// - Link bit pairs channels onto channel 0 pin
// - Buffered: last written pair takes over at overflow
// - Linked mode releases channel 1 pin to GPIO
// - Mode pair 0:1 unbuffered, 1:0 buffered
// - Edge/level 1:0 clears pin, 1:1 sets it
// - Overflow toggle clear means no toggle, 0% duty
// - Full duty plus overflow toggle gives 100% duty
// - Wrap flag sets; interrupt only when enabled
// - Channel flag on compare; interrupt when enabled
// - Wait mode counts on, blocks register access
// - Stop mode halts, keeps all state
// - Break state freezes the counter
// - Break with clear enable 0 protects flags
// - Break with clear enable 1 allows lasting clears
// - Prescale code 111 selects external count clock
// - Overflow toggle flips pin at period limit
// - Prescale codes 000-110 divide by 1 to 64
// - Counter restarts from zero after period match
`timescale 1ns/1ps
`include "tpc_defines.vh"
module tpc_pwm_pair
(
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // System modes
  input wire waitMode,
  input wire stopMode,
  input wire breakState,
  input wire breakClearEnable,
  // Count control
  input wire counterHaltBit,
  input wire counterClear,
  input wire [2:0] prescaleSelect,
  input wire extCountClock,
  input wire wrapIrqEnable,
  input wire periodWrite,
  input wire [15:0] periodData,
  // Channel control, index 0 and 1
  input wire [1:0] channelIrqEnable,
  input wire linkModeBit,
  input wire [1:0] unbufferedSelectBit,
  input wire [1:0] overflowToggleBit,
  input wire [1:0] fullDutyBit,
  input wire [3:0] edgeLevelSelect,
  input wire [1:0] valueWrite,
  input wire [31:0] valueData,
  // Flag clearing: status read arms, zero-write completes
  input wire wrapStatusRead,
  input wire wrapClearWrite,
  input wire [1:0] chanStatusRead,
  input wire [1:0] chanClearWrite,
  // Status
  output reg [15:0] countValue,
  output reg wrapFlag,
  output reg [1:0] channelEventFlag,
  output reg irqRequest,
  output reg bufferSelect,
  // Pins
  output reg channel0Pin,
  output reg channel1Pin,
  output reg channel1Timer
);
  reg [15:0] periodLimit; // Period limit pair
  reg [15:0] chanValue0; // Channel 0 value pair
  reg [15:0] chanValue1; // Channel 1 value pair
  reg pendBuf; // Buffered pair written last (0 or 1)
  reg wrapArmed; // First step of wrap clear done
  reg [1:0] chanArmed; // First step of channel clear done
  wire tick; // Counter advance enable
  wire run; // Counter is allowed to move
  wire regAccess; // CPU register access allowed
  wire flagClrOk; // Clears may act on flags
  wire atLimit; // Counter sits on the period limit
  wire wrapEvt; // Overflow event this tick
  wire [1:0] cmpEvt; // Compare events this tick
  wire [15:0] activeValue0; // Value steering channel 0 output

  // Halt, stop and break all freeze counting; wait does not
  assign run = ~counterHaltBit & ~stopMode & ~breakState;
  // No register access from the CPU while waiting
  assign regAccess = ~waitMode;
  // Break without clear enable blocks flag clears
  assign flagClrOk = regAccess & (~breakState | breakClearEnable);
  assign atLimit = (countValue == periodLimit);
  assign wrapEvt = tick & atLimit;
  // Buffered mode picks the active pair
  assign activeValue0 = (linkModeBit && bufferSelect) ? chanValue1 : chanValue0;
  // Compare on exact match
  assign cmpEvt[0] = tick & (countValue == activeValue0);
  assign cmpEvt[1] = tick & ~linkModeBit & (countValue == chanValue1);

  // Counter clock source
  tpc_prescaler uPre
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .clearPre(counterClear & regAccess),
    .run(run),
    .prescaleSelect(prescaleSelect),
    .extCountClock(extCountClock),
    .tick(tick)
  );

  // Pin action on compare for one channel
  function cmpAction;
    input [1:0] els;
    input cur;
    begin
      case (els)
        `TPC_ELS_CLEAR: cmpAction = 1'b0;
        `TPC_ELS_SET: cmpAction = 1'b1;
        `TPC_ELS_TOGGLE: cmpAction = ~cur;
        default: cmpAction = cur;
      endcase
    end
  endfunction

  // Counter, period and channel value registers
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      countValue <= `TPC_COUNT_RST;
      periodLimit <= `TPC_PERIOD_RST;
      chanValue0 <= 16'h0000;
      chanValue1 <= 16'h0000;
    end
    else
    begin
      // Clear takes priority; a held counter still clears to zero
      if (counterClear && regAccess)
        countValue <= `TPC_COUNT_RST;
      else if (wrapEvt)
        countValue <= `TPC_COUNT_RST;
      else if (tick)
        countValue <= countValue + 16'h0001;
      if (periodWrite && regAccess)
        periodLimit <= periodData;
      // Writes land at once, no shadowing for unbuffered use
      if (valueWrite[0] && regAccess)
        chanValue0 <= valueData[15:0];
      if (valueWrite[1] && regAccess)
        chanValue1 <= valueData[31:16];
    end
  end

  // Buffered pair tracking: last written pair takes over at overflow
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pendBuf <= 1'b0;
      bufferSelect <= 1'b0;
    end
    else if (!linkModeBit)
    begin
      // Leaving linked mode returns to channel 0 first
      pendBuf <= 1'b0;
      bufferSelect <= 1'b0;
    end
    else
    begin
      if (valueWrite[1] && regAccess)
        pendBuf <= 1'b1;
      else if (valueWrite[0] && regAccess)
        pendBuf <= 1'b0;
      if (wrapEvt)
        bufferSelect <= (valueWrite[1] && regAccess) ? 1'b1 :
                        (valueWrite[0] && regAccess) ? 1'b0 : pendBuf;
    end
  end

  // Channel pins: force first, then compare action, then overflow toggle
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      channel0Pin <= 1'b0;
      channel1Pin <= 1'b0;
      channel1Timer <= 1'b1;
    end
    else
    begin
      // Channel 1 pin belongs to the timer only when unlinked
      channel1Timer <= ~linkModeBit;
      // Full duty with toggle holds the pulse level; compare is ignored
      if (fullDutyBit[0] && overflowToggleBit[0])
        channel0Pin <= ~cmpAction(edgeLevelSelect[1:0], channel0Pin) | 
                       (edgeLevelSelect[1:0] == `TPC_ELS_TOGGLE);
      else if (cmpEvt[0] && (linkModeBit || unbufferedSelectBit[0]))
        channel0Pin <= cmpAction(edgeLevelSelect[1:0], channel0Pin);
      else if (wrapEvt && overflowToggleBit[0])
        channel0Pin <= ~channel0Pin;
      if (linkModeBit)
        channel1Pin <= 1'b0;
      else if (fullDutyBit[1] && overflowToggleBit[1])
        channel1Pin <= ~cmpAction(edgeLevelSelect[3:2], channel1Pin) |
                       (edgeLevelSelect[3:2] == `TPC_ELS_TOGGLE);
      else if (cmpEvt[1] && unbufferedSelectBit[1])
        channel1Pin <= cmpAction(edgeLevelSelect[3:2], channel1Pin);
      else if (wrapEvt && overflowToggleBit[1])
        channel1Pin <= ~channel1Pin;
    end
  end

  // Sticky flags with two-step clear; a new event always wins over the clear
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrapFlag <= 1'b0;
      wrapArmed <= 1'b0;
      channelEventFlag <= 2'h0;
      chanArmed <= 2'h0;
      irqRequest <= 1'b0;
    end
    else
    begin
      // Arming survives break so the second step can finish later
      if (wrapEvt)
      begin
        wrapFlag <= 1'b1;
        wrapArmed <= 1'b0;
      end
      else if (wrapClearWrite && wrapArmed && flagClrOk)
      begin
        wrapFlag <= 1'b0;
        wrapArmed <= 1'b0;
      end
      else if (wrapStatusRead && wrapFlag && regAccess)
        wrapArmed <= 1'b1;
      if (cmpEvt[0] || (cmpEvt[1] && !linkModeBit))
        chanArmed <= chanArmed & ~cmpEvt;
      else
        chanArmed <= chanArmed;
      channelEventFlag <= channelEventFlag | cmpEvt;
      if (!cmpEvt[0] && chanClearWrite[0] && chanArmed[0] && flagClrOk)
      begin
        channelEventFlag[0] <= 1'b0;
        chanArmed[0] <= 1'b0;
      end
      else if (!cmpEvt[0] && chanStatusRead[0] && channelEventFlag[0] && regAccess)
        chanArmed[0] <= 1'b1;
      if (!cmpEvt[1] && chanClearWrite[1] && chanArmed[1] && flagClrOk)
      begin
        channelEventFlag[1] <= 1'b0;
        chanArmed[1] <= 1'b0;
      end
      else if (!cmpEvt[1] && chanStatusRead[1] && channelEventFlag[1] && regAccess)
        chanArmed[1] <= 1'b1;
      // Interrupt only where enabled; also wakes from wait
      irqRequest <= (wrapFlag & wrapIrqEnable) |
                    (channelEventFlag[0] & channelIrqEnable[0]) |
                    (channelEventFlag[1] & channelIrqEnable[1] & ~linkModeBit);
    end
  end
endmodule

// ---- tb/tpc_pwm_props.sv ----
// Port-level checks for the two-channel PWM timer
`timescale 1ns/1ps
module tpc_pwm_props
(
  // Clock and reset
  input logic core_clk,
  input logic nrst,
  // Modes and control
  input logic waitMode,
  input logic stopMode,
  input logic breakState,
  input logic breakClearEnable,
  input logic counterHaltBit,
  input logic counterClear,
  input logic wrapIrqEnable,
  input logic [1:0] channelIrqEnable,
  input logic linkModeBit,
  // Status and pins
  input logic [15:0] countValue,
  input logic wrapFlag,
  input logic [1:0] channelEventFlag,
  input logic irqRequest,
  input logic channel1Pin,
  input logic channel1Timer
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Counter held with no clear; three cycles drain the tick pipeline
  sequence s_frozen;
    (counterHaltBit || stopMode || breakState) && !counterClear;
  endsequence
  // Flags may stay or rise but not fall
  sequence s_flags_kept;
    (wrapFlag || !$past(wrapFlag)) &&
      ((channelEventFlag & $past(channelEventFlag)) == $past(channelEventFlag));
  endsequence
  a_frozen_count_holds: assert property (s_frozen[*3] |=> $stable(countValue))
    else $error("held count moved");
  a_wrap_at_zero: assert property ($rose(wrapFlag) |-> countValue == 16'h0000)
    else $error("wrap flag rose off zero");
  a_wrap_sets_flag: assert property (countValue == 16'h0000 &&
      $past(countValue) != 16'h0000 && !$past(counterClear) |-> wrapFlag)
    else $error("wrap without flag");
  a_irq_tracks_flags: assert property (nrst |=> irqRequest ==
      $past((wrapFlag && wrapIrqEnable) || (channelEventFlag[0] && channelIrqEnable[0]) ||
      (channelEventFlag[1] && channelIrqEnable[1] && !linkModeBit)))
    else $error("irq does not follow flags");
  a_wait_keeps_flags: assert property (waitMode |=> s_flags_kept)
    else $error("flag cleared in wait");
  a_break_guards_flags: assert property (breakState && !breakClearEnable |=> s_flags_kept)
    else $error("flag cleared in guarded break");
  a_link_frees_pin: assert property (linkModeBit[*2] |-> !channel1Timer && !channel1Pin)
    else $error("channel 1 pin kept in link mode");
  a_unlinked_owns_pin: assert property (!linkModeBit[*2] |-> channel1Timer)
    else $error("channel 1 pin lost unlinked");
endmodule
bind tpc_pwm_pair tpc_pwm_props tpc_pwm_props_i (.*);

// ---- tb/tpc_load_model.sv ----
// Load on the channel 0 pin: totals the cycles it sees the pin high
`timescale 1ns/1ps
module tpc_load_model
(
  // Clock and reset
  input logic core_clk,
  input logic nrst,
  // Pin and measuring window
  input logic pin,
  input logic measure,
  // Running total; the bench takes differences so no clear is needed
  output logic [15:0] highCnt
);
  // Count high samples only inside the window
  always @(posedge core_clk or negedge nrst)
    if (!nrst)
      highCnt <= 16'h0000;
    else if (measure)
      highCnt <= highCnt + {15'h0000, pin};
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/1ps
module tb;
  // Timer inputs
  logic core_clk, nrst, waitMode, stopMode, breakState, breakClearEnable, counterHaltBit;
  logic counterClear, extCountClock, wrapIrqEnable, periodWrite, linkModeBit, measure;
  logic wrapStatusRead, wrapClearWrite;
  logic [2:0] prescaleSelect;
  logic [15:0] periodData, c;
  logic [1:0] channelIrqEnable, unbufferedSelectBit, overflowToggleBit, fullDutyBit;
  logic [1:0] valueWrite, chanStatusRead, chanClearWrite;
  logic [3:0] edgeLevelSelect;
  logic [31:0] valueData;
  // Timer outputs
  wire [15:0] countValue, highCnt;
  wire [1:0] channelEventFlag;
  wire wrapFlag, irqRequest, bufferSelect, channel0Pin, channel1Pin, channel1Timer;
  int error_cnt, check_count, cycles, n;
  tpc_pwm_pair tpc_pwm_pair_i (.*);
  tpc_load_model tpc_load_model_i (.core_clk, .nrst, .pin(channel0Pin), .measure, .highCnt);
  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      results;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // Halt and clear, period, width, mode, then release
  task automatic setup(input [15:0] per, v, input lnk, input [1:0] els, tov, fd, input [2:0] ps);
    @(posedge core_clk);
    counterHaltBit <= 1'h1;
    counterClear <= 1'h1;
    @(posedge core_clk);
    counterClear <= 1'h0;
    periodWrite <= 1'h1;
    periodData <= per;
    @(posedge core_clk);
    periodWrite <= 1'h0;
    valueWrite <= 2'h1;
    valueData <= {16'h0000, v};
    @(posedge core_clk);
    valueWrite <= 2'h0;
    linkModeBit <= lnk;
    unbufferedSelectBit <= {1'h1, !lnk};
    {overflowToggleBit, fullDutyBit, prescaleSelect} <= {tov, fd, ps};
    edgeLevelSelect <= {2'h2, els};
    @(posedge core_clk);
    counterHaltBit <= 1'h0;
    cyc(1);
  endtask
  // High cycles over one period, after two periods to settle
  task automatic duty(input [15:0] hi);
    cyc(20);
    c = highCnt;
    @(posedge core_clk) measure <= 1'h1;
    repeat (10) @(posedge core_clk);
    measure <= 1'h0;
    cyc(1);
    check(highCnt - c, hi);
  endtask
  // One-cycle strobe: 0 arm wrap, 1 clear wrap, 2 arm ch0, 3 clear ch0
  task automatic pulse(input int k);
    @(posedge core_clk);
    {chanClearWrite[0], chanStatusRead[0], wrapClearWrite, wrapStatusRead} <= 4'h1 << k;
    @(posedge core_clk);
    {chanClearWrite[0], chanStatusRead[0], wrapClearWrite, wrapStatusRead} <= 4'h0;
    cyc(1);
  endtask
  task automatic t_wrap;
    check({countValue, wrapFlag, channelEventFlag, irqRequest, channel1Timer}, 21'h1);
    @(posedge core_clk) wrapIrqEnable <= 1'h1;
    setup(16'h0003, 16'h0001, 1'h0, 2'h2, 2'h1, 2'h0, 3'h0);
    for (n = 0; n < 50 && wrapFlag !== 1'h1; n++) cyc(1);
    check(countValue, 16'h0000);
    cyc(1);
    check({irqRequest, countValue}, 17'h10001);
    @(posedge core_clk) wrapIrqEnable <= 1'h0;
    cyc(2);
    check({wrapFlag, channelEventFlag[0], irqRequest}, 3'h6);
    @(posedge core_clk) channelIrqEnable <= 2'h1;
    cyc(2);
    check(irqRequest, 1'h1);
    @(posedge core_clk) channelIrqEnable <= 2'h0;
    $display("wrap test done");
  endtask
  task automatic t_duty;
    // Width, compare action, overflow toggle, full duty, high cycles; period 9
    // A pulse spans the zero count through the match count, so width is value plus one
    logic [23:0] tab [4] = '{24'h431005, 24'h420000, 24'h42110A, 24'h421005};
    foreach (tab[i])
    begin
      setup(16'h0009, {12'h000, tab[i][23:20]}, 1'h0, tab[i][17:16], tab[i][13:12],
            tab[i][9:8], 3'h0);
      duty({8'h00, tab[i][7:0]});
    end
    @(posedge core_clk) valueWrite <= 2'h1;
    valueData <= 32'h00000007;
    @(posedge core_clk) valueWrite <= 2'h0;
    duty(16'h0008);
    $display("duty test done");
  endtask
  task automatic t_link;
    setup(16'h0009, 16'h0002, 1'h1, 2'h2, 2'h1, 2'h0, 3'h0);
    check({channel1Timer, channel1Pin, bufferSelect}, 3'h0);
    duty(16'h0003);
    @(posedge core_clk) valueWrite <= 2'h2;
    valueData <= 32'h00060000;
    @(posedge core_clk) valueWrite <= 2'h0;
    cyc(12);
    check(bufferSelect, 1'h1);
    duty(16'h0007);
    $display("link test done");
  endtask
  task automatic t_hold;
    setup(16'h0009, 16'h0004, 1'h0, 2'h2, 2'h1, 2'h0, 3'h0);
    @(posedge core_clk) breakState <= 1'h1;
    cyc(3);
    c = countValue;
    cyc(5);
    check(countValue, c);
    @(posedge core_clk) {breakState, stopMode} <= 2'h1;
    cyc(5);
    check(countValue, c);
    @(posedge core_clk) {stopMode, waitMode} <= 2'h1;
    cyc(3);
    check(countValue !== c, 1'h1);
    @(posedge core_clk) {waitMode, counterHaltBit} <= 2'h1;
    pulse(0);
    @(posedge core_clk) breakState <= 1'h1;
    pulse(1);
    check(wrapFlag, 1'h1);
    @(posedge core_clk) breakState <= 1'h0;
    pulse(1);
    check(wrapFlag, 1'h0);
    @(posedge core_clk) {breakState, breakClearEnable} <= 2'h3;
    pulse(2);
    pulse(3);
    @(posedge core_clk) {breakState, breakClearEnable} <= 2'h0;
    cyc(2);
    check(channelEventFlag[0], 1'h0);
    $display("hold test done");
  endtask
  task automatic t_scale;
    for (int p = 0; p < 7; p++)
    begin
      setup(16'hFFFF, 16'hFFFF, 1'h0, 2'h2, 2'h0, 2'h0, p[2:0]);
      for (n = 0; n < 300 && countValue !== 16'h0002; n++) cyc(1);
      for (n = 0; n < 300 && countValue !== 16'h0003; n++) cyc(1);
      check(n, 1 << p);
    end
    setup(16'hFFFF, 16'hFFFF, 1'h0, 2'h2, 2'h0, 2'h0, 3'h7);
    c = countValue;
    repeat (5)
    begin
      @(posedge core_clk) extCountClock <= 1'h1;
      repeat (4) @(posedge core_clk);
      extCountClock <= 1'h0;
      repeat (3) @(posedge core_clk);
    end
    cyc(6);
    check(countValue - c, 16'h0005);
    $display("prescale test done");
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {nrst, waitMode, stopMode, breakState, breakClearEnable, counterClear, extCountClock,
     wrapIrqEnable, periodWrite, linkModeBit, measure, wrapStatusRead, wrapClearWrite,
     prescaleSelect, periodData, channelIrqEnable, unbufferedSelectBit, overflowToggleBit,
     fullDutyBit, valueWrite, chanStatusRead, chanClearWrite, edgeLevelSelect, valueData} = '0;
    counterHaltBit = 1'h1;
    repeat (10) @(posedge core_clk);
    nrst <= 1'h1;
    cyc(2);
    t_wrap;
    t_duty;
    t_link;
    t_hold;
    t_scale;
    results;
  end
endmodule
